// [rtl/olp_loader.sv]
`timescale 1ns/1ns
`include "olp_consts.svh"
// Operation
// - 768 fuse bits are readable by the processor once reset is released.
// - Six banks, zero to five, 128 bits each, all sharing one layout.
// - Lowest 108 bits hold fixed fields; upper 20 are software or reserved.
// - Each bank can be programmed without disturbing any other bank.
// - Used flag zero means field invalid; one means field may be used.
// - MAC, ADC, frequency offset, IQ gain and IQ phase each own a flag.
// - IQ gain and phase trims load only when their used flags are one.
// - Shipped bank one holds MAC, frequency offset and IQ fields, flagged.
module olp_loader
  import olp_pkg::*;
#(
  parameter int              NUM_BANKS     = `OLP_NUM_BANKS,
  parameter int              BANK_BITS     = `OLP_BANK_BITS,
  parameter int              POS_INVALID   = `OLP_POS_INVALID,
  parameter int              POS_BANK_USED = `OLP_POS_BANK_USED,
  parameter int              POS_MAC_USED  = `OLP_POS_MAC_USED,
  parameter int              POS_MAC       = `OLP_POS_MAC,
  parameter int              W_MAC         = `OLP_W_MAC,
  parameter int              POS_ADC_USED  = `OLP_POS_ADC_USED,
  parameter int              POS_ADC       = `OLP_POS_ADC,
  parameter int              W_ADC         = `OLP_W_ADC,
  parameter int              POS_FRQ_USED  = `OLP_POS_FRQ_USED,
  parameter int              POS_FRQ       = `OLP_POS_FRQ,
  parameter int              W_FRQ         = `OLP_W_FRQ,
  parameter int              POS_IQG_USED  = `OLP_POS_IQG_USED,
  parameter int              POS_IQG       = `OLP_POS_IQG,
  parameter int              W_IQG         = `OLP_W_IQG,
  parameter int              POS_IQP_USED  = `OLP_POS_IQP_USED,
  parameter int              POS_IQP       = `OLP_POS_IQP,
  parameter int              W_IQP         = `OLP_W_IQP,
  parameter logic [W_MAC-1:0] SHIP_MAC     = 48'h02_00_00_00_00_01,
  parameter logic [W_FRQ-1:0] SHIP_FRQ     = 15'h0000,
  parameter logic [W_IQG-1:0] SHIP_IQG     = 11'h000,
  parameter logic [W_IQP-1:0] SHIP_IQP     = 10'h000
) (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic             reload_i,
  input  wire logic             prog_req_i,
  input  wire logic [2:0]       prog_bank_i,
  input  wire logic [6:0]       prog_bit_i,
  output logic                  prog_ready_o,
  output logic                  busy_o,
  output logic                  load_done_o,
  output logic                  no_bank_o,
  output logic [2:0]            sel_bank_o,
  output logic [W_MAC-1:0]      mac_o,
  output logic                  mac_valid_flag_o,
  output logic [W_ADC-1:0]      adc_cal_o,
  output logic                  adc_valid_flag_o,
  output logic [W_FRQ-1:0]      freq_off_o,
  output logic                  freq_valid_flag_o,
  output logic [W_IQG-1:0]      iq_gain_trim_o,
  output logic                  iq_gain_valid_flag_o,
  output logic [W_IQP-1:0]      iq_phase_trim_o,
  output logic                  iq_phase_valid_flag_o
);
  localparam int FIXED_BITS = `OLP_FIXED_BITS;
  localparam int SHIP_BANK  = `OLP_SHIP_BANK;

  // Every field must stay in the fixed region; bank index is three bits
  if (NUM_BANKS < 2 || NUM_BANKS > 8 || BANK_BITS != 128 ||
      POS_MAC + W_MAC > FIXED_BITS || POS_ADC + W_ADC > FIXED_BITS ||
      POS_FRQ + W_FRQ > FIXED_BITS || POS_IQG + W_IQG > FIXED_BITS ||
      POS_IQP + W_IQP > FIXED_BITS || POS_IQP_USED >= FIXED_BITS) begin : g_bad_geometry
    $error("olp_loader: unsupported bank geometry");
  end

  function automatic logic [BANK_BITS-1:0] ship_word();
    logic [BANK_BITS-1:0] w;
    w = '0;
    w[POS_BANK_USED]        = 1'b1;
    w[POS_MAC_USED]         = 1'b1;
    w[POS_MAC +: W_MAC]     = SHIP_MAC;
    w[POS_FRQ_USED]         = 1'b1;
    w[POS_FRQ +: W_FRQ]     = SHIP_FRQ;
    w[POS_IQG_USED]         = 1'b1;
    w[POS_IQG +: W_IQG]     = SHIP_IQG;
    w[POS_IQP_USED]         = 1'b1;
    w[POS_IQP +: W_IQP]     = SHIP_IQP;
    return w;
  endfunction

  localparam logic [BANK_BITS-1:0] SHIP_WORD = ship_word();
  localparam logic [2:0]           TOP_BANK  = 3'(NUM_BANKS - 1);

  // Fuse array; reset stands in for the factory-blown pattern
  logic [BANK_BITS-1:0] fuse_r   [NUM_BANKS];
  logic [BANK_BITS-1:0] fuse_nxt [NUM_BANKS];
  logic                 prog_take;

  assign prog_ready_o = 1'b1;
  assign prog_take    = prog_req_i && (int'(prog_bank_i) < NUM_BANKS);

  always_comb begin
    for (int i = 0; i < NUM_BANKS; i++) begin
      fuse_nxt[i] = fuse_r[i];
    end
    // Only one bit of one bank moves; a blown bit never clears
    if (prog_take) begin
      fuse_nxt[prog_bank_i][prog_bit_i] = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < NUM_BANKS; i++) begin
        fuse_r[i] <= (i == SHIP_BANK) ? SHIP_WORD : '0;
      end
    end else begin
      for (int i = 0; i < NUM_BANKS; i++) begin
        fuse_r[i] <= fuse_nxt[i];
      end
    end
  end

  olp_bank_if #(
    .BANK_BITS(BANK_BITS), .W_MAC(W_MAC), .W_ADC(W_ADC),
    .W_FRQ(W_FRQ), .W_IQG(W_IQG), .W_IQP(W_IQP)
  ) bank_if ();

  olp_bank_eval #(
    .POS_INVALID  (POS_INVALID),
    .POS_BANK_USED(POS_BANK_USED),
    .POS_MAC_USED (POS_MAC_USED),
    .POS_MAC      (POS_MAC),
    .POS_ADC_USED (POS_ADC_USED),
    .POS_ADC      (POS_ADC),
    .POS_FRQ_USED (POS_FRQ_USED),
    .POS_FRQ      (POS_FRQ),
    .POS_IQG_USED (POS_IQG_USED),
    .POS_IQG      (POS_IQG),
    .POS_IQP_USED (POS_IQP_USED),
    .POS_IQP      (POS_IQP)
  ) u_eval (
    .b(bank_if.eval)
  );

  // Scanner: one bank per clock, highest index first
  olp_state_t       state_r;
  olp_state_t       state_nxt;
  logic [2:0]       idx_r;
  logic [2:0]       idx_nxt;
  logic [2:0]       sel_nxt;
  logic             capture;

  assign bank_if.word = fuse_r[idx_r];

  always_comb begin
    state_nxt = state_r;
    idx_nxt   = idx_r;
    sel_nxt   = sel_bank_o;
    capture   = 1'b0;
    case (state_r)
      OLP_ST_SCAN: begin
        if (bank_if.ok) begin
          capture   = 1'b1;
          sel_nxt   = idx_r;
          state_nxt = OLP_ST_DONE;
        end else if (idx_r == 3'h0) begin
          state_nxt = OLP_ST_NONE;
        end else begin
          idx_nxt = idx_r - 3'h1;
        end
      end
      OLP_ST_DONE, OLP_ST_NONE: begin
        // Rescan lets freshly programmed banks take effect without reset
        if (reload_i) begin
          state_nxt = OLP_ST_SCAN;
          idx_nxt   = TOP_BANK;
        end
      end
      default: begin
        state_nxt = OLP_ST_SCAN;
        idx_nxt   = TOP_BANK;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r    <= OLP_ST_SCAN;
      idx_r      <= TOP_BANK;
      sel_bank_o <= 3'h0;
    end else begin
      state_r    <= state_nxt;
      idx_r      <= idx_nxt;
      sel_bank_o <= sel_nxt;
    end
  end

  assign busy_o      = (state_r == OLP_ST_SCAN);
  assign load_done_o = (state_r == OLP_ST_DONE);
  assign no_bank_o   = (state_r == OLP_ST_NONE);

  // Parameter outputs, held from the chosen bank
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mac_o                 <= '0;
      mac_valid_flag_o      <= 1'b0;
      adc_cal_o             <= '0;
      adc_valid_flag_o      <= 1'b0;
      freq_off_o            <= '0;
      freq_valid_flag_o     <= 1'b0;
      iq_gain_trim_o        <= '0;
      iq_gain_valid_flag_o  <= 1'b0;
      iq_phase_trim_o       <= '0;
      iq_phase_valid_flag_o <= 1'b0;
    end else if (capture) begin
      mac_o                 <= bank_if.mac;
      mac_valid_flag_o      <= bank_if.mac_v;
      adc_cal_o             <= bank_if.adc;
      adc_valid_flag_o      <= bank_if.adc_v;
      freq_off_o            <= bank_if.frq;
      freq_valid_flag_o     <= bank_if.frq_v;
      iq_gain_trim_o        <= bank_if.iqg;
      iq_gain_valid_flag_o  <= bank_if.iqg_v;
      iq_phase_trim_o       <= bank_if.iqp;
      iq_phase_valid_flag_o <= bank_if.iqp_v;
    end
  end

  // Checking helpers
  logic any_ok;
  always_comb begin
    any_ok = 1'b0;
    for (int i = 0; i < NUM_BANKS; i++) begin
      any_ok = any_ok | (fuse_r[i][POS_BANK_USED] & ~fuse_r[i][POS_INVALID]);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // Checked when the choice is made; later retirement only shows after a rescan
  a_sel_bank_valid: assert property ($rose(load_done_o) && !$past(prog_take) |->
    fuse_r[sel_bank_o][POS_BANK_USED] && !fuse_r[sel_bank_o][POS_INVALID])
    else $error("selected bank is not valid");
  a_none_means_empty: assert property ($rose(no_bank_o) && !$past(prog_take) |-> !any_ok)
    else $error("no bank reported while a valid bank exists");
  a_scan_bounded: assert property ($rose(busy_o) |-> ##[1:8] !busy_o)
    else $error("scan did not finish within the bank count");
  a_iq_gain_gated: assert property (!iq_gain_valid_flag_o |-> iq_gain_trim_o == '0)
    else $error("iq gain trim loaded with flag clear");
  a_iq_phase_gated: assert property (!iq_phase_valid_flag_o |-> iq_phase_trim_o == '0)
    else $error("iq phase trim loaded with flag clear");
  a_mac_follows_fuse: assert property (capture && bank_if.mac_v |=>
    mac_valid_flag_o && mac_o == $past(bank_if.word[POS_MAC +: W_MAC]))
    else $error("mac output differs from fuse field");
  a_adc_flag_gate: assert property (capture && !bank_if.adc_v |=> !adc_valid_flag_o && adc_cal_o == '0)
    else $error("adc value passed with flag clear");
  a_prog_blows_bit: assert property (prog_take |=> fuse_r[$past(prog_bank_i)][$past(prog_bit_i)])
    else $error("programmed fuse bit not set");
  a_prog_bank_iso: assert property (prog_take && prog_bank_i != 3'h0 |=> $stable(fuse_r[0]))
    else $error("programming disturbed another bank");
  a_ship_bank_one: assert property ($rose(nrst_i) |-> fuse_r[SHIP_BANK][POS_MAC_USED])
    else $error("shipped bank lacks mac flag");

  c_done_top: cover property (capture && idx_r == TOP_BANK);
  c_done_lower: cover property (capture && idx_r < TOP_BANK);
  c_no_bank: cover property ($rose(no_bank_o));
  c_reload: cover property (load_done_o && reload_i ##1 busy_o);
endmodule // olp_loader

// [rtl/olp_consts.svh]
`ifndef OLP_CONSTS_SVH
`define OLP_CONSTS_SVH

`define OLP_NUM_BANKS      6
`define OLP_BANK_BITS      128
`define OLP_FIXED_BITS     108
`define OLP_SHIP_BANK      1

`define OLP_POS_INVALID    0
`define OLP_POS_BANK_USED  1
`define OLP_POS_MAC_USED   2
`define OLP_POS_MAC        3
`define OLP_W_MAC          48
`define OLP_POS_ADC_USED   51
`define OLP_POS_ADC        52
`define OLP_W_ADC          8
`define OLP_POS_FRQ_USED   60
`define OLP_POS_FRQ        61
`define OLP_W_FRQ          15
`define OLP_POS_IQG_USED   76
`define OLP_POS_IQG        77
`define OLP_W_IQG          11
`define OLP_POS_IQP_USED   88
`define OLP_POS_IQP        89
`define OLP_W_IQP          10

`endif

// [rtl/olp_pkg.sv]
package olp_pkg;
  typedef enum logic [2:0] {
    OLP_ST_SCAN = 3'b001,
    OLP_ST_DONE = 3'b010,
    OLP_ST_NONE = 3'b100
  } olp_state_t;
endpackage

// [rtl/olp_bank_if.sv]
`timescale 1ns/1ns
interface olp_bank_if #(
  parameter int BANK_BITS = 128,
  parameter int W_MAC     = 48,
  parameter int W_ADC     = 8,
  parameter int W_FRQ     = 15,
  parameter int W_IQG     = 11,
  parameter int W_IQP     = 10
);
  logic [BANK_BITS-1:0] word;
  logic                 ok;
  logic [W_MAC-1:0]     mac;
  logic                 mac_v;
  logic [W_ADC-1:0]     adc;
  logic                 adc_v;
  logic [W_FRQ-1:0]     frq;
  logic                 frq_v;
  logic [W_IQG-1:0]     iqg;
  logic                 iqg_v;
  logic [W_IQP-1:0]     iqp;
  logic                 iqp_v;
  modport src  (output word, input ok, mac, mac_v, adc, adc_v, frq, frq_v, iqg, iqg_v, iqp, iqp_v);
  modport eval (input word, output ok, mac, mac_v, adc, adc_v, frq, frq_v, iqg, iqg_v, iqp, iqp_v);
endinterface

// [rtl/olp_bank_eval.sv]
`timescale 1ns/1ns
`include "olp_consts.svh"
module olp_bank_eval #(
  parameter int POS_INVALID   = `OLP_POS_INVALID,
  parameter int POS_BANK_USED = `OLP_POS_BANK_USED,
  parameter int POS_MAC_USED  = `OLP_POS_MAC_USED,
  parameter int POS_MAC       = `OLP_POS_MAC,
  parameter int POS_ADC_USED  = `OLP_POS_ADC_USED,
  parameter int POS_ADC       = `OLP_POS_ADC,
  parameter int POS_FRQ_USED  = `OLP_POS_FRQ_USED,
  parameter int POS_FRQ       = `OLP_POS_FRQ,
  parameter int POS_IQG_USED  = `OLP_POS_IQG_USED,
  parameter int POS_IQG       = `OLP_POS_IQG,
  parameter int POS_IQP_USED  = `OLP_POS_IQP_USED,
  parameter int POS_IQP       = `OLP_POS_IQP
) (
  olp_bank_if.eval b
);
  // Bank usable only when validated and never retired
  assign b.ok    = b.word[POS_BANK_USED] & ~b.word[POS_INVALID];
  // A value whose flag is zero is forced to zero so it cannot leak out
  assign b.mac_v = b.word[POS_MAC_USED];
  assign b.mac   = b.mac_v ? b.word[POS_MAC +: $bits(b.mac)] : '0;
  assign b.adc_v = b.word[POS_ADC_USED];
  assign b.adc   = b.adc_v ? b.word[POS_ADC +: $bits(b.adc)] : '0;
  assign b.frq_v = b.word[POS_FRQ_USED];
  assign b.frq   = b.frq_v ? b.word[POS_FRQ +: $bits(b.frq)] : '0;
  assign b.iqg_v = b.word[POS_IQG_USED];
  assign b.iqg   = b.iqg_v ? b.word[POS_IQG +: $bits(b.iqg)] : '0;
  assign b.iqp_v = b.word[POS_IQP_USED];
  assign b.iqp   = b.iqp_v ? b.word[POS_IQP +: $bits(b.iqp)] : '0;
endmodule // olp_bank_eval

// [sim/olp_cpu_model.sv]
`timescale 1ns/1ns
`include "olp_consts.svh"
module olp_cpu_model (
  input  wire logic                    clk_i,
  input  wire logic                    nrst_i,
  input  wire logic                    load_done_i,
  input  wire logic [`OLP_W_MAC-1:0]   mac_i,
  output logic      [`OLP_W_MAC-1:0]   mac_seen_o
);
  logic                  done_q_r;
  logic [`OLP_W_MAC-1:0] mac_r;
  logic [`OLP_W_MAC-1:0] mac_nxt;
  // Firmware reads on each rise of done, after reset and after every rescan that finds a bank
  always_comb begin
    mac_nxt = (load_done_i && !done_q_r) ? mac_i : mac_r;
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      done_q_r <= 1'b0;
      mac_r    <= '0;
    end else begin
      done_q_r <= load_done_i;
      mac_r    <= mac_nxt;
    end
  end
  assign mac_seen_o = mac_r;
endmodule // olp_cpu_model

// [sim/testbench.sv]
`timescale 1ns/1ns
`include "olp_consts.svh"
module testbench;
  localparam logic [47:0] SMAC = 48'hA53C00123456;
  localparam logic [14:0] SFRQ = 15'h1ABC;
  localparam logic [10:0] SIQG = 11'h5A3;
  localparam logic [9:0]  SIQP = 10'h2C7;
  logic clk_i = 1'b0, nrst_i = 1'b0, reload_i = 1'b0, prog_req_i = 1'b0;
  logic [2:0] prog_bank_i = 3'h0, sel_bank_o;
  logic [6:0] prog_bit_i = 7'h00;
  logic prog_ready_o, busy_o, load_done_o, no_bank_o, mac_v, adc_v, frq_v, iqg_v, iqp_v;
  logic [47:0] mac_o, mac_seen;
  logic [7:0]  adc_o;
  logic [14:0] frq_o;
  logic [10:0] iqg_o;
  logic [9:0]  iqp_o;
  logic [127:0] fz [6];
  int err_total = 0, n_tests = 0;
  always #20 clk_i = ~clk_i;
  olp_loader #(.SHIP_MAC(SMAC), .SHIP_FRQ(SFRQ), .SHIP_IQG(SIQG), .SHIP_IQP(SIQP)) u_olp_loader (
    .clk_i(clk_i), .nrst_i(nrst_i), .reload_i(reload_i), .prog_req_i(prog_req_i),
    .prog_bank_i(prog_bank_i), .prog_bit_i(prog_bit_i), .prog_ready_o(prog_ready_o),
    .busy_o(busy_o), .load_done_o(load_done_o), .no_bank_o(no_bank_o), .sel_bank_o(sel_bank_o),
    .mac_o(mac_o), .mac_valid_flag_o(mac_v), .adc_cal_o(adc_o), .adc_valid_flag_o(adc_v),
    .freq_off_o(frq_o), .freq_valid_flag_o(frq_v), .iq_gain_trim_o(iqg_o),
    .iq_gain_valid_flag_o(iqg_v), .iq_phase_trim_o(iqp_o), .iq_phase_valid_flag_o(iqp_v));
  olp_cpu_model u_olp_cpu_model (.clk_i(clk_i), .nrst_i(nrst_i), .load_done_i(load_done_o),
    .mac_i(mac_o), .mac_seen_o(mac_seen));
  task automatic close_out;
    if (err_total == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [63:0] exp, logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [63:0] fv(logic [127:0] w, int f, int p, int n);
    fv = w[f] ? 64'((w >> p) & ((128'h1 << n) - 128'h1)) : 64'h0;
  endfunction
  task automatic expect_all;
    int s;
    logic [127:0] w;
    s = -1;
    for (int b = 5; b >= 0; b--) if (s < 0 && fz[b][`OLP_POS_BANK_USED] && !fz[b][`OLP_POS_INVALID]) s = b;
    chk("no_bank", 64'(s < 0), no_bank_o);
    chk("done", 64'(s >= 0), load_done_o);
    chk("ready", 64'h1, prog_ready_o);
    if (s >= 0) begin
      w = fz[s];
      chk("sel", 64'(s), sel_bank_o);
      chk("mac_v", 64'(w[`OLP_POS_MAC_USED]), mac_v);
      chk("mac", fv(w, `OLP_POS_MAC_USED, `OLP_POS_MAC, `OLP_W_MAC), mac_o);
      chk("adc_v", 64'(w[`OLP_POS_ADC_USED]), adc_v);
      chk("adc", fv(w, `OLP_POS_ADC_USED, `OLP_POS_ADC, `OLP_W_ADC), adc_o);
      chk("frq_v", 64'(w[`OLP_POS_FRQ_USED]), frq_v);
      chk("frq", fv(w, `OLP_POS_FRQ_USED, `OLP_POS_FRQ, `OLP_W_FRQ), frq_o);
      chk("iqg_v", 64'(w[`OLP_POS_IQG_USED]), iqg_v);
      chk("iqg", fv(w, `OLP_POS_IQG_USED, `OLP_POS_IQG, `OLP_W_IQG), iqg_o);
      chk("iqp_v", 64'(w[`OLP_POS_IQP_USED]), iqp_v);
      chk("iqp", fv(w, `OLP_POS_IQP_USED, `OLP_POS_IQP, `OLP_W_IQP), iqp_o);
    end
  endtask
  task automatic do_reset;
    int n;
    @(posedge clk_i) nrst_i <= 1'b0;
    for (int b = 0; b < 6; b++) fz[b] = '0;
    fz[1][`OLP_POS_BANK_USED] = 1'b1;
    fz[1][`OLP_POS_MAC_USED] = 1'b1;
    fz[1][`OLP_POS_FRQ_USED] = 1'b1;
    fz[1][`OLP_POS_IQG_USED] = 1'b1;
    fz[1][`OLP_POS_IQP_USED] = 1'b1;
    fz[1][`OLP_POS_MAC +: `OLP_W_MAC] = SMAC;
    fz[1][`OLP_POS_FRQ +: `OLP_W_FRQ] = SFRQ;
    fz[1][`OLP_POS_IQG +: `OLP_W_IQG] = SIQG;
    fz[1][`OLP_POS_IQP +: `OLP_W_IQP] = SIQP;
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      #1;
    end while (load_done_o !== 1'b1 && n < 20);
    chk("latency", 64'd5, 64'(n));
    expect_all;
    // Processor model latches one edge after done rises
    @(posedge clk_i);
    #1;
    chk("cpu_mac", 64'(SMAC), 64'(mac_seen));
  endtask
  // Drive held high across back-to-back bits; caller lowers it with rescan
  task automatic blow(int b, int p);
    @(posedge clk_i);
    prog_req_i  <= 1'b1;
    prog_bank_i <= 3'(b);
    prog_bit_i  <= 7'(p);
    if (b < 6) fz[b][p] = 1'b1;
  endtask
  task automatic put(int b, int p, int n, logic [63:0] v);
    for (int i = 0; i < n; i++) if (v[i]) blow(b, p + i);
  endtask
  task automatic rescan;
    int i;
    @(posedge clk_i) prog_req_i <= 1'b0;
    @(posedge clk_i) reload_i <= 1'b1;
    @(posedge clk_i) reload_i <= 1'b0;
    for (i = 0; i < 12; i++) begin
      #1;
      if (busy_o === 1'b0) break;
      @(posedge clk_i);
    end
    chk("scan_end", 64'h0, 64'(busy_o));
    expect_all;
  endtask
  initial begin
    #(40 * 20000);
    err_total++;
    close_out;
  end
  initial begin
    void'($urandom(32'h81525b23));
    do_reset;
    // Move parameters to bank three, skipping bank two
    blow(1, `OLP_POS_INVALID);
    blow(2, `OLP_POS_INVALID);
    put(3, `OLP_POS_MAC, `OLP_W_MAC, 64'h0000_5E00_5300_A1C3);
    put(3, `OLP_POS_ADC, `OLP_W_ADC, 64'hB6);
    put(3, `OLP_POS_FRQ, `OLP_W_FRQ, 64'(SFRQ));
    put(3, `OLP_POS_IQG, `OLP_W_IQG, 64'(SIQG));
    put(3, `OLP_POS_IQP, `OLP_W_IQP, 64'(SIQP));
    for (int f = 0; f < 5; f++) blow(3, `OLP_POS_MAC_USED + 0 * f);
    blow(3, `OLP_POS_ADC_USED);
    blow(3, `OLP_POS_FRQ_USED);
    blow(3, `OLP_POS_IQG_USED);
    blow(3, `OLP_POS_IQP_USED);
    blow(3, `OLP_POS_BANK_USED);
    rescan;
    chk("moved_sel", 64'h3, 64'(sel_bank_o));
    repeat (40) begin
      repeat (4) blow($urandom_range(0, 7), $urandom_range(0, 99));
      rescan;
    end
    for (int b = 0; b < 6; b++) blow(b, `OLP_POS_INVALID);
    rescan;
    do_reset;
    close_out;
  end
endmodule // testbench
